// File: design/pmc_defines.vh
`ifndef PMC_DEFINES_VH
`define PMC_DEFINES_VH

// clock and power-up timing
`define PMC_CLK_PERIOD_NS 5
`define PMC_TPR_MAX_NS 1000
`define PMC_PR_CYC (`PMC_TPR_MAX_NS / `PMC_CLK_PERIOD_NS)

// bus geometry
`define PMC_ADDR_W 12
`define PMC_DATA_W 32

// register byte offsets
`define PMC_MODE_OFS 12'h000
`define PMC_CELL_OFS 12'h004
`define PMC_STAT_OFS 12'h008
`define PMC_PT_BASE 12'h100
`define PMC_PT_LAST 12'h1FC

// mode register fields
`define PMC_MODE_LSB 0
`define PMC_MODE_MSB 1
`define PMC_PDEN_BIT 2
`define PMC_MODE_RST 3'h0

// macrocell architecture modes
`define PMC_ARCH_REG 2'h0
`define PMC_ARCH_CPLX 2'h1
`define PMC_ARCH_SIMP 2'h2

// per-cell config: 3 bits per cell, function in low 2, polarity above
`define PMC_CELL_BITS 3
`define PMC_CELL_RST 24'h000000
`define PMC_FN_REG 2'h0
`define PMC_FN_COMB 2'h1
`define PMC_FN_IN 2'h2

// status register fields
`define PMC_ST_PIN_LSB 0
`define PMC_ST_OE_LSB 8
`define PMC_ST_Q_LSB 16
`define PMC_ST_SLEEP_BIT 24
`define PMC_ST_READY_BIT 25

// structure
`define PMC_CELLS 8
`define PMC_PTS 8
`define PMC_PT_NUM 64
`define PMC_LITS 32
`define PMC_SLEEP_IN 2
`define PMC_INNER_A 3
`define PMC_INNER_B 4

// bus responses
`define PMC_RESP_OK 2'h0
`define PMC_RESP_ERR 2'h2

`endif

// File: design/pmc_macrocell.v
// Functional notes
// - in registered mode the clock pin is the common clock and the second pin the common oe_n; neither feeds the array.
// - every registered cell shares that one clock pin and that one oe_n pin.
// - a registered cell in registered mode drives only while oe_n is low and updates on the clock pin.
// - a registered cell sums all eight product terms into its register input.
// - a combinatorial cell in registered mode takes its enable from one product term and sums the other seven.
// - a cell set as dedicated input never drives its pin, except the two inner cells in simple mode.
// - each cell is set on its own as registered, combinatorial or input.
// - in complex mode the clock and oe_n pins become array inputs on the feedback slots of the two outer cells.
// - in simple mode each pin but the inner two feeds back through its inward neighbour's slot.
// - in simple mode the two inner cells are always outputs and feed nothing back.
// - with sleep enabled the reused input no longer reaches the array.
// - after reset all cell registers read low so registered pins read high.
// - while asleep all pins and cell registers hold and every input but the sleep pin and the register bus is ignored.
`timescale 1ns/10ps
`default_nettype none
`include "pmc_defines.vh"

module pmc_macrocell (
    // clock and reset
    input wire clk,
    input wire rst,
    // axi4-lite write address
    input wire [`PMC_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // axi4-lite write data
    input wire [`PMC_DATA_W-1:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [`PMC_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // axi4-lite read data
    output reg [`PMC_DATA_W-1:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // dedicated pins
    input wire pin_clk,
    input wire pin_oe_n,
    input wire [7:0] pin_in,
    // macrocell pins
    input wire [7:0] io_in,
    output reg [7:0] io_out,
    output reg [7:0] io_oe_n
);

    // 0 mode, 1 cell config, 2 status, 3 product term, 4 unmapped
    function [2:0] reg_kind;
        input [`PMC_ADDR_W-1:0] a;
        begin
            if (a[1:0] != 2'h0) begin
                reg_kind = 3'h4;
            end else if (a == `PMC_MODE_OFS) begin
                reg_kind = 3'h0;
            end else if (a == `PMC_CELL_OFS) begin
                reg_kind = 3'h1;
            end else if (a == `PMC_STAT_OFS) begin
                reg_kind = 3'h2;
            end else if (a >= `PMC_PT_BASE && a <= `PMC_PT_LAST) begin
                reg_kind = 3'h3;
            end else begin
                reg_kind = 3'h4;
            end
        end
    endfunction

    function [31:0] merge_strb;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0] strb;
        integer b;
        begin
            merge_strb = old_v;
            for (b = 0; b < 4; b = b + 1) begin
                if (strb[b]) begin
                    merge_strb[b*8 +: 8] = new_v[b*8 +: 8];
                end
            end
        end
    endfunction

    // configuration state
    reg [2:0] mode_reg;
    reg [23:0] cell_reg;
    reg [31:0] pt_mask_reg [0:`PMC_PT_NUM-1];

    // pin synchronisers
    reg clk_s1_reg, clk_s2_reg, clk_s3_reg;
    reg oe_s1_reg, oe_s2_reg;
    reg [7:0] in_s1_reg, in_s2_reg;
    reg [7:0] io_s1_reg, io_s2_reg;

    // macrocell registers and power-up timer
    reg [7:0] q_reg;
    reg [7:0] pr_cnt_reg;
    localparam [31:0] PR_INIT = `PMC_PR_CYC;

    // bus state
    reg aw_got_reg, w_got_reg;
    reg [`PMC_ADDR_W-1:0] aw_addr_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;

    wire [1:0] arch = mode_reg[`PMC_MODE_MSB:`PMC_MODE_LSB];
    wire pd_en = mode_reg[`PMC_PDEN_BIT];
    wire sleeping = pd_en & in_s2_reg[`PMC_SLEEP_IN];
    wire pr_done = (pr_cnt_reg == 8'h00);
    wire is_reg_mode = (arch != `PMC_ARCH_CPLX) && (arch != `PMC_ARCH_SIMP);
    wire is_simple = (arch == `PMC_ARCH_SIMP);
    // the edge samples are taken from the second and third stages so the first never feeds logic
    wire clk_rise = clk_s2_reg & ~clk_s3_reg;

    // feedback slots into the array
    reg [7:0] fb;
    integer k;
    always @* begin
        for (k = 0; k < 8; k = k + 1) begin
            fb[k] = io_s2_reg[k];
        end
        if (is_reg_mode) begin
            for (k = 0; k < 8; k = k + 1) begin
                if (cell_reg[k*3 +: 2] == `PMC_FN_REG) begin
                    fb[k] = q_reg[k];
                end
            end
        end else if (is_simple) begin
            // outer half shifts inward by one, inner pair has no slot
            fb[0] = 1'b0;
            fb[1] = io_s2_reg[0];
            fb[2] = io_s2_reg[1];
            fb[3] = io_s2_reg[2];
            fb[4] = io_s2_reg[5];
            fb[5] = io_s2_reg[6];
            fb[6] = io_s2_reg[7];
            fb[7] = 1'b0;
        end else begin
            fb[0] = clk_s2_reg;
            fb[7] = oe_s2_reg;
        end
    end

    // dedicated inputs; the sleep input is cut from the array when enabled
    reg [7:0] din;
    always @* begin
        din = in_s2_reg;
        if (pd_en) begin
            din[`PMC_SLEEP_IN] = 1'b0;
        end
    end

    wire [15:0] sig = {fb, din};
    wire [`PMC_LITS-1:0] lit;
    wire [`PMC_PT_NUM-1:0] pt;
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : g_lit
            // a removed input yields false on both polarities
            wire cut = pd_en && (g == `PMC_SLEEP_IN);
            assign lit[2*g] = sig[g] & ~cut;
            assign lit[2*g+1] = ~sig[g] & ~cut;
        end
        for (g = 0; g < `PMC_PT_NUM; g = g + 1) begin : g_pt
            // an all-clear mask is an unused term and stays false
            assign pt[g] = (|pt_mask_reg[g]) & (&(lit | ~pt_mask_reg[g]));
        end
    endgenerate

    // per-cell pin and register next values
    reg [7:0] out_next, oe_n_next, q_next;
    reg [1:0] fn;
    reg pol, sum8, sum7, pte;
    integer m;
    always @* begin
        fn = 2'h0;
        pol = 1'b0;
        sum8 = 1'b0;
        sum7 = 1'b0;
        pte = 1'b0;
        q_next = q_reg;
        out_next = io_out;
        oe_n_next = io_oe_n;
        for (m = 0; m < 8; m = m + 1) begin
            fn = cell_reg[m*3 +: 2];
            pol = cell_reg[m*3+2];
            sum8 = |pt[m*8 +: 8];
            sum7 = |pt[m*8+1 +: 7];
            pte = pt[m*8];
            if (is_reg_mode && fn == `PMC_FN_REG) begin
                if (clk_rise && pr_done) begin
                    q_next[m] = sum8;
                end
                out_next[m] = ~q_reg[m];
                oe_n_next[m] = oe_s2_reg;
            end else if (is_simple && (m == `PMC_INNER_A || m == `PMC_INNER_B)) begin
                out_next[m] = sum8 ^ pol;
                oe_n_next[m] = 1'b0;
            end else if (fn == `PMC_FN_IN) begin
                out_next[m] = 1'b0;
                oe_n_next[m] = 1'b1;
            end else if (is_simple) begin
                out_next[m] = sum8 ^ pol;
                oe_n_next[m] = 1'b0;
            end else begin
                out_next[m] = sum7 ^ pol;
                oe_n_next[m] = ~pte;
            end
        end
        if (sleeping) begin
            // everything holds, including pins already released
            q_next = q_reg;
            out_next = io_out;
            oe_n_next = io_oe_n;
        end
        if (!pr_done) begin
            q_next = 8'h00;
        end
    end

    // pins and macrocell registers
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            clk_s1_reg <= 1'b0;
            clk_s2_reg <= 1'b0;
            clk_s3_reg <= 1'b0;
            oe_s1_reg <= 1'b1;
            oe_s2_reg <= 1'b1;
            in_s1_reg <= 8'h00;
            in_s2_reg <= 8'h00;
            io_s1_reg <= 8'h00;
            io_s2_reg <= 8'h00;
            q_reg <= 8'h00;
            pr_cnt_reg <= PR_INIT[7:0];
            io_out <= 8'hFF;
            io_oe_n <= 8'hFF;
        end else begin
            clk_s1_reg <= pin_clk;
            clk_s2_reg <= clk_s1_reg;
            clk_s3_reg <= clk_s2_reg;
            oe_s1_reg <= pin_oe_n;
            oe_s2_reg <= oe_s1_reg;
            in_s1_reg <= pin_in;
            in_s2_reg <= in_s1_reg;
            io_s1_reg <= io_in;
            io_s2_reg <= io_s1_reg;
            if (!pr_done) begin
                pr_cnt_reg <= pr_cnt_reg - 8'h01;
            end
            q_reg <= q_next;
            io_out <= out_next;
            io_oe_n <= oe_n_next;
        end
    end

    // axi4-lite write side: address and data may come in either order
    wire aw_hs = s_axi_awvalid & s_axi_awready;
    wire w_hs = s_axi_wvalid & s_axi_wready;
    wire do_write = aw_got_reg & w_got_reg & ~s_axi_bvalid;
    wire [2:0] wkind = reg_kind(aw_addr_reg);
    wire [5:0] widx = aw_addr_reg[7:2];
    wire [31:0] mode_mrg = merge_strb({29'h0, mode_reg}, w_data_reg, w_strb_reg);
    wire [31:0] cell_mrg = merge_strb({8'h00, cell_reg}, w_data_reg, w_strb_reg);
    integer i;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PMC_RESP_OK;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            aw_addr_reg <= 12'h000;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            mode_reg <= `PMC_MODE_RST;
            cell_reg <= `PMC_CELL_RST;
            for (i = 0; i < `PMC_PT_NUM; i = i + 1) begin
                pt_mask_reg[i] <= 32'h00000000;
            end
        end else begin
            if (aw_hs) begin
                aw_addr_reg <= s_axi_awaddr;
                aw_got_reg <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (w_hs) begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                w_got_reg <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wkind == 3'h4) ? `PMC_RESP_ERR : `PMC_RESP_OK;
                case (wkind)
                    3'h0: begin
                        mode_reg <= mode_mrg[2:0];
                    end
                    3'h1: begin
                        cell_reg <= cell_mrg[23:0];
                    end
                    3'h3: begin
                        pt_mask_reg[widx] <= merge_strb(pt_mask_reg[widx], w_data_reg,
                            w_strb_reg);
                    end
                    default: begin
                    end
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // axi4-lite read side: one cycle from address to data
    wire [2:0] rkind = reg_kind(s_axi_araddr);
    reg [31:0] rd_val;
    always @* begin
        rd_val = 32'h00000000;
        case (rkind)
            3'h0: rd_val = {29'h0, mode_reg};
            3'h1: rd_val = {8'h00, cell_reg};
            3'h2: begin
                rd_val[`PMC_ST_PIN_LSB +: 8] = io_out;
                rd_val[`PMC_ST_OE_LSB +: 8] = ~io_oe_n;
                rd_val[`PMC_ST_Q_LSB +: 8] = q_reg;
                rd_val[`PMC_ST_SLEEP_BIT] = sleeping;
                rd_val[`PMC_ST_READY_BIT] = pr_done;
            end
            3'h3: rd_val = pt_mask_reg[s_axi_araddr[7:2]];
            default: rd_val = 32'h00000000;
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PMC_RESP_OK;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= (rkind == 3'h4) ? `PMC_RESP_ERR : `PMC_RESP_OK;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // pmc_macrocell

`default_nettype wire

// File: tb/pmc_checker_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "pmc_defines.vh"
module pmc_checker (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register bus
    input wire logic [`PMC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [`PMC_DATA_W-1:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // pins
    input wire logic pin_clk,
    input wire logic pin_oe_n,
    input wire logic [7:0] pin_in,
    input wire logic [7:0] io_out,
    input wire logic [7:0] io_oe_n
);
    logic [11:0] a_reg;
    logic [31:0] d_reg;
    logic [2:0] mode_reg;
    logic [23:0] cell_reg;
    logic [1:0] age_reg;
    int up_reg;
    logic [7:0] rm;
    logic [7:0] im;
    wire regm = mode_reg[1:0] == `PMC_ARCH_REG || mode_reg[1:0] == 2'h3;
    wire simp = mode_reg[1:0] == `PMC_ARCH_SIMP;
    // config is copied only once answered, so pin checks wait a few cycles after any write
    wire ok = age_reg == 2'h3 && !mode_reg[`PMC_PDEN_BIT];
    always_comb begin
        for (int m = 0; m < 8; m++) begin
            rm[m] = regm && cell_reg[3*m +: 2] == `PMC_FN_REG;
            im[m] = cell_reg[3*m +: 2] == `PMC_FN_IN && !(simp && (m == 3 || m == 4));
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            a_reg <= 12'h000;
            d_reg <= 32'h0;
            mode_reg <= 3'h0;
            cell_reg <= 24'h0;
            age_reg <= 2'h3;
            up_reg <= 0;
        end else begin
            if (up_reg < `PMC_PR_CYC) up_reg <= up_reg + 1;
            if (age_reg != 2'h3) age_reg <= age_reg + 2'h1;
            if (s_axi_awvalid && s_axi_awready) a_reg <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) d_reg <= s_axi_wdata;
            if (s_axi_bvalid && s_axi_bready) begin
                age_reg <= 2'h0;
                if (s_axi_bresp == `PMC_RESP_OK && a_reg == `PMC_MODE_OFS)
                    mode_reg <= d_reg[2:0];
                if (s_axi_bresp == `PMC_RESP_OK && a_reg == `PMC_CELL_OFS)
                    cell_reg <= d_reg[23:0];
            end
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_reset_pins_high: assert property ($fell(rst) |-> io_out == 8'hFF && io_oe_n == 8'hFF)
        else $error("pins not released from reset high");
    a_powerup_high: assert property (up_reg < `PMC_PR_CYC && ok |-> (io_out & rm) == rm)
        else $error("registered pin low during power-up");
    a_reg_clock_only: assert property ((ok && $stable(pin_clk)) [*7] |->
        ((io_out ^ $past(io_out)) & rm) == 8'h00) else $error("register moved without clock");
    a_reg_oe_common: assert property ((ok && $stable(pin_oe_n)) [*5] |->
        (io_oe_n & rm) == (pin_oe_n ? rm : 8'h00)) else $error("registered enable wrong");
    a_input_never_drives: assert property (ok |-> (io_oe_n & im) == im)
        else $error("input cell drives");
    a_inner_always_drive: assert property (ok && simp |-> io_oe_n[4:3] == 2'b00)
        else $error("inner cell not driving");
    a_sleep_holds: assert property (
        (mode_reg[`PMC_PDEN_BIT] && pin_in[`PMC_SLEEP_IN]) [*6] |->
        $stable(io_out) && $stable(io_oe_n)) else $error("pins moved while asleep");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
    c_sleep: cover property (mode_reg[`PMC_PDEN_BIT] && pin_in[`PMC_SLEEP_IN]);
    c_simple: cover property (ok && simp);
    c_clocked: cover property (ok && $rose(pin_clk));
endmodule // pmc_checker
bind pmc_macrocell pmc_checker pmc_checker_i (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .pin_clk, .pin_oe_n, .pin_in, .io_out, .io_oe_n);
`default_nettype wire

// File: tb/pmc_board.sv
`timescale 1ns/10ps
`default_nettype none
module pmc_board (
    // clock
    input wire logic clk,
    // board requests
    input wire logic clk_lvl,
    input wire logic [7:0] ext,
    // device pins
    input wire logic [7:0] io_out,
    input wire logic [7:0] io_oe_n,
    output logic pin_clk,
    output logic [7:0] io_in
);
    // the board clock stands still unless the bench moves it
    initial pin_clk = 1'b0;
    always @(posedge clk) pin_clk <= clk_lvl;
    // a released pin shows the board level, a driven one the device value
    assign io_in = (io_oe_n & ext) | (~io_oe_n & io_out);
endmodule // pmc_board
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "pmc_defines.vh"
module testbench;
    localparam logic [1:0] OK = `PMC_RESP_OK;
    localparam logic [11:0] ST = `PMC_STAT_OFS;
    logic clk, rst, awv, wv, bready, arv, rready, pclk_lvl, pin_oe_n;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, st, r;
    logic [7:0] pin_in, ext;
    logic [3:0] strb;
    wire awready, wready, bvalid, arready, rvalid, pin_clk;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] io_in, io_out, io_oe_n;
    int num_errors, checked, seed, cyc;
    logic [31:0] mdl [int];
    pmc_macrocell pmc_macrocell_i (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
        .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_clk(pin_clk), .pin_oe_n(pin_oe_n),
        .pin_in(pin_in), .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n));
    pmc_board pmc_board_i (.clk(clk), .clk_lvl(pclk_lvl), .ext(ext), .io_out(io_out),
        .io_oe_n(io_oe_n), .pin_clk(pin_clk), .io_in(io_in));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out;
        $display("checked %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            close_out();
        end
    end
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic done;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        {awv, wv, bready} <= 3'h7;
        done = 1'b0;
        while (!done) begin
            @(posedge clk);
            if (awready === 1'b1) awv <= 1'b0;
            if (wready === 1'b1) wv <= 1'b0;
            if (bvalid === 1'b1) begin
                bready <= 1'b0;
                done = 1'b1;
            end
        end
        chk("bresp", er, {30'h0, bresp});
        // status is read-only, the fields above their width read zero
        if (er == OK && a != ST) begin
            if (!mdl.exists(a)) mdl[a] = 32'h0;
            for (int b = 0; b < 4; b++) if (strb[b]) mdl[a][8*b +: 8] = d[8*b +: 8];
            mdl[a] &= (a == 0) ? 32'h7 : (a == 4) ? 32'hFF_FFFF : 32'hFFFF_FFFF;
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [1:0] er);
        logic done;
        @(posedge clk);
        araddr <= a;
        {arv, rready} <= 2'h3;
        done = 1'b0;
        while (!done) begin
            @(posedge clk);
            if (arready === 1'b1) arv <= 1'b0;
            if (rvalid === 1'b1) begin
                rready <= 1'b0;
                st = rdata;
                done = 1'b1;
            end
        end
        chk("rresp", er, {30'h0, rresp});
    endtask
    task automatic stc(input logic [31:0] m, input logic [31:0] e);
        repeat (8) @(posedge clk);
        rd(ST, OK);
        chk("status", e, st & m);
    endtask
    task automatic cfg(input logic [2:0] md, input logic [23:0] cl);
        wr(`PMC_MODE_OFS, {29'h0, md}, OK);
        wr(`PMC_CELL_OFS, {8'h0, cl}, OK);
        for (int a = 0; a < 8; a += 4) begin
            rd(12'(a), OK);
            chk("config", mdl[a], st);
        end
    endtask
    function automatic logic [11:0] pt(input int m, input int t);
        return `PMC_PT_BASE + 12'(4 * (8 * m + t));
    endfunction
    initial begin
        {awv, wv, bready, arv, rready, pclk_lvl} = 6'h00;
        {awaddr, araddr, wdata, pin_in, ext} = 72'h0;
        rst = 1'b1;
        pin_oe_n = 1'b1;
        {cyc, num_errors, checked} = 96'h0;
        seed = 73;
        strb = 4'hF;
        mdl[0] = 32'h0;
        mdl[4] = 32'h0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        cfg(3'h0, 24'h0);
        stc(32'h03FF_FFFF, 32'h0000_00FF);
        wr(ST, 32'hFFFF_FFFF, OK);
        wr(12'h00C, 32'h1, `PMC_RESP_ERR);
        rd(12'h00C, `PMC_RESP_ERR);
        repeat (`PMC_PR_CYC) @(posedge clk);
        stc(32'h0200_0000, 32'h0200_0000);
        pin_oe_n <= 1'b0;
        for (int t = 0; t < 8; t++) begin
            wr(pt(0, t), 32'h4, OK);
            if (t > 0) wr(pt(0, t - 1), 32'h0, OK);
            for (int v = 1; v >= 0; v--) begin
                pin_in <= {6'h00, v[0], 1'b0};
                repeat (4) @(posedge clk);
                pclk_lvl <= 1'b1;
                repeat (6) @(posedge clk);
                pclk_lvl <= 1'b0;
                stc(32'h0001_0101, {15'h0, v[0], 7'h0, 1'b1, 7'h0, ~v[0]});
            end
        end
        // registered mode since cell 0 keeps its register
        cfg(3'h0, 24'h000088);
        wr(pt(1, 0), 32'h40, OK);
        wr(pt(1, 1), 32'h1, OK);
        for (int i = 0; i < 6; i++) begin
            r = $random(seed);
            pin_in <= r[7:0];
            pin_oe_n <= r[8];
            pclk_lvl <= r[9];
            stc(32'h0702, {21'h0, 1'b0, r[3], ~r[8], 6'h0, r[0], 1'b0});
        end
        cfg(3'h1, 24'h000008);
        wr(pt(1, 1), 32'h0001_0000, OK);
        wr(pt(1, 2), 32'h8000_0000, OK);
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            pin_oe_n <= r[8];
            pclk_lvl <= r[9];
            stc(32'h2, {30'h0, r[9] | ~r[8], 1'b0});
        end
        cfg(3'h2, 24'h00240A);
        wr(pt(1, 1), 32'h0, OK);
        wr(pt(1, 2), 32'h0, OK);
        wr(pt(1, 0), 32'h0004_0000, OK);
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            ext <= r[7:0];
            stc(32'h1902, 32'h1800 | {30'h0, r[0], 1'b0});
        end
        cfg(3'h4, 24'h000008);
        wr(pt(1, 0), 32'h0, OK);
        wr(pt(1, 1), 32'h20, OK);
        pin_in <= 8'h00;
        stc(32'h2, 32'h0);
        cfg(3'h0, 24'h000008);
        stc(32'h2, 32'h2);
        cfg(3'h4, 24'h000008);
        wr(pt(1, 1), 32'h1, OK);
        pin_in <= 8'h01;
        stc(32'h0100_0002, 32'h2);
        pin_in <= 8'h05;
        stc(32'h0100_0002, 32'h0100_0002);
        pin_in <= 8'h04;
        stc(32'h0100_0002, 32'h0100_0002);
        pin_in <= 8'h00;
        stc(32'h0100_0002, 32'h0);
        // a partial strobe must merge only the enabled byte
        strb <= 4'h2;
        wr(pt(7, 7), 32'hA5A5_A5A5, OK);
        strb <= 4'hF;
        rd(pt(7, 7), OK);
        chk("ptmask", mdl[pt(7, 7)], st);
        close_out();
    end
endmodule // testbench
`default_nettype wire
